// ### hw/ulp_cfg.svh
// Constants for the transceiver pin-control block
`ifndef ULP_CFG_SVH
`define ULP_CFG_SVH
// ==========================================================
// Timing
`define ULP_CLK_MHZ 20
`define ULP_POWERUP_NS 1000
`define ULP_POWERUP_CYC ((`ULP_POWERUP_NS * `ULP_CLK_MHZ + 999) / 1000)
`define ULP_CNT_W 6
// ==========================================================
// Receive-status byte layout
`define ULP_RXCMD_LINE_LSB 0
`define ULP_RXCMD_VBUS_LSB 2
`define ULP_RXCMD_ROLE_BIT 6
// ==========================================================
// Values
`define ULP_VBUS_GOOD 2'h3
`define ULP_VBUS_FAULT 2'h0
`define ULP_BUS_IDLE 8'h00
`endif

// ### hw/ulp_pkg.sv
// Types for the transceiver pin-control block
`default_nettype none
package ulp_pkg;
  // ==========================================================
  // Link-interface sequencer states
  typedef enum logic [3:0] {
    ST_POWERUP,
    ST_TURN_OUT,
    ST_IDLE,
    ST_LINK_TX,
    ST_TURN_IN,
    ST_CMD,
    ST_REG,
    ST_RX,
    ST_RX_END,
    ST_LOWPOWER
  } ulp_state_type;
endpackage : ulp_pkg
`default_nettype wire

// ### hw/ulp_pin_control.sv
// Link-interface pin control of the USB transceiver
`include "ulp_cfg.svh"
`default_nettype none
module ulp_pin_control #(
  parameter int POWERUP_CYC = `ULP_POWERUP_CYC
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic select_n_i,
  input wire logic stp_i,
  input wire logic [7:0] data_i,
  output logic [7:0] data_o,
  output logic data_oe_o,
  output logic dir_o,
  output logic dir_oe_o,
  output logic nxt_o,
  output logic nxt_oe_o,
  output logic ifclk_o,
  input wire logic fault_i,
  input wire logic cable_role_pin_i,
  output logic cable_role_o,
  output logic ext_power_switch_n_o,
  output logic ext_power_switch_n_oe_o,
  output logic pump_on_o,
  input wire logic use_external_vbus_indicator_i,
  input wire logic indicator_polarity_invert_i,
  input wire logic indicator_passthrough_i,
  input wire logic external_supply_enable_i,
  input wire logic internal_pump_enable_i,
  input wire logic low_power_i,
  input wire logic [1:0] line_state_i,
  input wire logic [1:0] vbus_state_i,
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_data_i,
  input wire logic rx_last_i,
  output logic rx_ready_o,
  input wire logic rd_req_i,
  input wire logic [7:0] rd_data_i,
  output logic rd_ack_o,
  output logic [7:0] tx_data_o,
  output logic tx_valid_o,
  output logic tx_last_o
);
  // ==========================================================
  // Declarations
  ulp_pkg::ulp_state_type state_q, state_d;
  logic [`ULP_CNT_W-1:0] pwr_cnt_q;
  logic [1:0] fault_sync_q;
  logic [1:0] role_sync_q;
  logic rd_pend_q;
  logic [7:0] rd_byte_q;
  logic [7:0] sent_q;
  logic [7:0] rxcmd;
  logic [1:0] vbus_rep;
  logic fault_act;
  logic stp_live;
  logic sending;
  logic rx_take;
  logic [7:0] data_d;
  logic oe_d;
  logic nxt_d;
  logic dir_d;

  // ==========================================================
  // Pin synchronisers for the asynchronous fault and role pins
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      fault_sync_q <= 2'h0;
      role_sync_q <= 2'h0;
    end else begin
      fault_sync_q <= {fault_sync_q[0], fault_i};
      role_sync_q <= {role_sync_q[0], cable_role_pin_i};
    end
  end

  // ==========================================================
  // Status byte assembly; fault forces a bad supply state
  always_comb begin
    fault_act = use_external_vbus_indicator_i &
                indicator_passthrough_i &
                (fault_sync_q[1] ^ indicator_polarity_invert_i);
    vbus_rep = fault_act ? `ULP_VBUS_FAULT : vbus_state_i;
    rxcmd = 8'h00;
    rxcmd[`ULP_RXCMD_LINE_LSB +: 2] = line_state_i;
    rxcmd[`ULP_RXCMD_VBUS_LSB +: 2] = vbus_rep;
    rxcmd[`ULP_RXCMD_ROLE_BIT] = role_sync_q[1];
  end

  // Stop is only heard while the chip is selected
  assign stp_live = stp_i & ~select_n_i;
  // States in which this end owns the bus and an abort may end it
  assign sending = (state_q == ulp_pkg::ST_TURN_IN) |
                   (state_q == ulp_pkg::ST_CMD) |
                   (state_q == ulp_pkg::ST_REG) |
                   (state_q == ulp_pkg::ST_RX) |
                   (state_q == ulp_pkg::ST_RX_END);
  assign rx_take = (state_q == ulp_pkg::ST_RX) & rx_valid_i & rx_ready_o;

  // ==========================================================
  // Sequencer next state
  always_comb begin
    state_d = state_q;
    case (state_q)
      ulp_pkg::ST_POWERUP: begin
        if (pwr_cnt_q == '0) begin
          state_d = ulp_pkg::ST_TURN_OUT;
        end
      end
      // Bus content is not trusted for the cycle after a flip
      ulp_pkg::ST_TURN_OUT: begin
        state_d = ulp_pkg::ST_IDLE;
      end
      ulp_pkg::ST_IDLE: begin
        if (low_power_i) begin
          state_d = ulp_pkg::ST_LOWPOWER;
        end else if (data_i != `ULP_BUS_IDLE) begin
          state_d = ulp_pkg::ST_LINK_TX;
        end else if (rd_pend_q | rx_valid_i | (rxcmd != sent_q)) begin
          state_d = ulp_pkg::ST_TURN_IN;
        end
      end
      ulp_pkg::ST_LINK_TX: begin
        if (stp_live) begin
          state_d = ulp_pkg::ST_IDLE;
        end
      end
      // Read data beats receive data, which beats status
      ulp_pkg::ST_TURN_IN: begin
        if (rd_pend_q) begin
          state_d = ulp_pkg::ST_REG;
        end else if (rx_valid_i) begin
          state_d = ulp_pkg::ST_RX;
        end else begin
          state_d = ulp_pkg::ST_CMD;
        end
      end
      ulp_pkg::ST_CMD: begin
        state_d = ulp_pkg::ST_TURN_OUT;
      end
      ulp_pkg::ST_REG: begin
        state_d = ulp_pkg::ST_TURN_OUT;
      end
      ulp_pkg::ST_RX: begin
        if (rx_take & rx_last_i) begin
          state_d = ulp_pkg::ST_RX_END;
        end
      end
      ulp_pkg::ST_RX_END: begin
        state_d = ulp_pkg::ST_TURN_OUT;
      end
      ulp_pkg::ST_LOWPOWER: begin
        if (!low_power_i) begin
          state_d = ulp_pkg::ST_TURN_OUT;
        end
      end
      default: begin
        state_d = ulp_pkg::ST_IDLE;
      end
    endcase
    // Abort by the link wins over any send in progress
    if (sending & stp_live) begin
      state_d = ulp_pkg::ST_TURN_OUT;
    end
  end

  // ==========================================================
  // Pin values for the coming cycle, decided from the next state
  always_comb begin
    dir_d = (state_d == ulp_pkg::ST_LOWPOWER) |
            (state_d == ulp_pkg::ST_POWERUP) |
            (state_d == ulp_pkg::ST_TURN_IN) |
            (state_d == ulp_pkg::ST_CMD) |
            (state_d == ulp_pkg::ST_REG) |
            (state_d == ulp_pkg::ST_RX) |
            (state_d == ulp_pkg::ST_RX_END);
    oe_d = dir_d & (state_d != ulp_pkg::ST_TURN_IN) &
           (state_d != ulp_pkg::ST_POWERUP) &
           (state_d != ulp_pkg::ST_LOWPOWER);
    data_d = rxcmd;
    nxt_d = 1'b0;
    if (state_d == ulp_pkg::ST_REG) begin
      data_d = rd_byte_q;
    end else if (rx_take & dir_d) begin
      data_d = rx_data_i;
      nxt_d = 1'b1;
    end else if (state_d == ulp_pkg::ST_LINK_TX) begin
      nxt_d = ~stp_live;
    end
  end

  // ==========================================================
  // Sequencer state and power-up hold counter
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_q <= ulp_pkg::ST_POWERUP;
      pwr_cnt_q <= `ULP_CNT_W'(POWERUP_CYC - 1);
    end else begin
      state_q <= state_d;
      if (pwr_cnt_q != '0) begin
        pwr_cnt_q <= pwr_cnt_q - `ULP_CNT_W'(1);
      end
    end
  end

  // ==========================================================
  // Bus pins; chip select floats direction and next a cycle later
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      dir_o <= 1'b1;
      dir_oe_o <= 1'b0;
      nxt_o <= 1'b0;
      nxt_oe_o <= 1'b0;
      data_o <= 8'h00;
      data_oe_o <= 1'b0;
    end else begin
      dir_o <= dir_d;
      dir_oe_o <= ~select_n_i;
      nxt_o <= nxt_d;
      nxt_oe_o <= ~select_n_i;
      data_o <= data_d;
      data_oe_o <= oe_d & ~select_n_i;
    end
  end

  // ==========================================================
  // Last status byte sent, so only changes raise a new one
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sent_q <= 8'h00;
    end else if (oe_d & ~nxt_d & (state_d != ulp_pkg::ST_REG)) begin
      sent_q <= rxcmd;
    end
  end

  // ==========================================================
  // Register read hand-in; a new request wins over the clear
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rd_pend_q <= 1'b0;
      rd_byte_q <= 8'h00;
      rd_ack_o <= 1'b0;
    end else begin
      rd_ack_o <= (state_d == ulp_pkg::ST_REG);
      if (rd_req_i) begin
        rd_pend_q <= 1'b1;
        rd_byte_q <= rd_data_i;
      end else if (state_d == ulp_pkg::ST_REG) begin
        rd_pend_q <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Receive stream ready; drops with the last byte or an abort
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rx_ready_o <= 1'b0;
    end else begin
      rx_ready_o <= (state_d == ulp_pkg::ST_RX);
    end
  end

  // ==========================================================
  // Bytes from the link; the command byte opens, stop closes
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tx_data_o <= 8'h00;
      tx_valid_o <= 1'b0;
      tx_last_o <= 1'b0;
    end else begin
      tx_data_o <= data_i;
      tx_valid_o <= ((state_q == ulp_pkg::ST_IDLE) &
                     (state_d == ulp_pkg::ST_LINK_TX)) |
                    ((state_q == ulp_pkg::ST_LINK_TX) & nxt_o &
                     ~stp_live);
      tx_last_o <= (state_q == ulp_pkg::ST_LINK_TX) & stp_live;
    end
  end

  // ==========================================================
  // Supply controls; open drain only ever pulls low
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ext_power_switch_n_o <= 1'b1;
      ext_power_switch_n_oe_o <= 1'b0;
      pump_on_o <= 1'b0;
    end else begin
      ext_power_switch_n_o <= ~external_supply_enable_i;
      ext_power_switch_n_oe_o <= external_supply_enable_i;
      pump_on_o <= internal_pump_enable_i;
    end
  end

  // ==========================================================
  // Interface clock out and role; the clock parks in low power
  // so the oscillator may be stopped behind it
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ifclk_o <= 1'b0;
      cable_role_o <= 1'b0;
    end else begin
      if (state_q != ulp_pkg::ST_LOWPOWER) begin
        ifclk_o <= ~ifclk_o;
      end else begin
        ifclk_o <= 1'b0;
      end
      cable_role_o <= role_sync_q[1];
    end
  end
endmodule : ulp_pin_control
`default_nettype wire

// ### verification/ulp_pin_control_properties.sv
// Port-level checks of the link-interface pin control
`default_nettype none
module ulp_pin_control_properties #(
  parameter int POWERUP_CYC = 2
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic select_n_i,
  input wire logic stp_i,
  input wire logic data_oe_o,
  input wire logic dir_o,
  input wire logic dir_oe_o,
  input wire logic nxt_o,
  input wire logic nxt_oe_o,
  input wire logic rd_ack_o,
  input wire logic tx_valid_o,
  input wire logic external_supply_enable_i,
  input wire logic ext_power_switch_n_o,
  input wire logic ext_power_switch_n_oe_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  // ==========================================================
  // Steps
  // Bus stays blocked for the first two edges after reset
  sequence s_blocked;
    dir_o ##1 dir_o;
  endsequence
  // A granted stop that the block must obey
  sequence s_live_stop;
    dir_o && data_oe_o && stp_i && !select_n_i;
  endsequence
  // ==========================================================
  // Properties
  chk_powerup_dir: assert property ($rose(resetn_i) |-> s_blocked)
    else $error("dir low in power-up");
  chk_listen_quiet: assert property (!dir_o |-> !data_oe_o)
    else $error("bus driven while dir low");
  chk_turn_cycle: assert property ($changed(dir_o) |-> !data_oe_o)
    else $error("bus driven in turnaround");
  chk_abort_drop: assert property (s_live_stop |=> !dir_o)
    else $error("dir kept after stop");
  chk_float_pins: assert property (select_n_i |=>
    !dir_oe_o && !nxt_oe_o)
    else $error("pins driven while deselected");
  chk_read_quiet: assert property (rd_ack_o |-> dir_o && !nxt_o)
    else $error("next high on read data");
  chk_tx_ask: assert property ($rose(nxt_o) && !dir_o |-> tx_valid_o)
    else $error("next without command byte");
  chk_switch_on: assert property (external_supply_enable_i |=>
    !ext_power_switch_n_o && ext_power_switch_n_oe_o)
    else $error("supply switch not pulled low");
endmodule : ulp_pin_control_properties
bind ulp_pin_control ulp_pin_control_properties #(
  .POWERUP_CYC(POWERUP_CYC)
) u_chk (.clk_i, .resetn_i, .select_n_i, .stp_i, .data_oe_o, .dir_o,
  .dir_oe_o, .nxt_o, .nxt_oe_o, .rd_ack_o, .tx_valid_o,
  .external_supply_enable_i, .ext_power_switch_n_o, .ext_power_switch_n_oe_o);
`default_nettype wire

// ### verification/ulp_link_model.sv
// Link-side model: idle zeros, one three-byte packet, optional abort
`default_nettype none
module ulp_link_model (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic dir_i,
  input wire logic nxt_i,
  input wire logic go_i,
  input wire logic abort_i,
  input wire logic [23:0] pkt_i,
  output logic [7:0] data_o,
  output logic data_oe_o,
  output logic stp_o,
  output logic busy_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] idx_q;
  // Command goes out unasked; later bytes advance only on next,
  // and stop follows the last byte in a cycle of its own
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      idx_q <= 3'h0;
    end else if (dir_i) begin
      idx_q <= 3'h0;
    end else if (idx_q == 3'h0) begin
      idx_q <= go_i ? 3'h1 : 3'h0;
    end else if (idx_q == 3'h4) begin
      idx_q <= 3'h0;
    end else if (idx_q == 3'h1 || nxt_i) begin
      idx_q <= idx_q + 3'h1;
    end
  end
  // Byte on the bus for each step; the stop cycle carries zero
  always_comb begin
    case (idx_q)
      3'h1: data_o = pkt_i[23:16];
      3'h2: data_o = pkt_i[15:8];
      3'h3: data_o = pkt_i[7:0];
      default: data_o = 8'h00;
    endcase
  end
  // Released while the block owns the bus; pull-downs then read zero
  assign data_oe_o = !dir_i;
  assign stp_o = (idx_q == 3'h4) | (abort_i & dir_i);
  assign busy_o = idx_q != 3'h0;
endmodule : ulp_link_model
`default_nettype wire

// ### verification/ulp_pin_control_tb_top.sv
// Self-checking bench for the link-interface pin control
`default_nettype none
module ulp_pin_control_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i, resetn_i, select_n_i, stp_i, data_oe_o, dir_o, dir_oe_o;
  logic nxt_o, nxt_oe_o, ifclk_o, fault_i, cable_role_pin_i, cable_role_o;
  logic ext_power_switch_n_o, ext_power_switch_n_oe_o, pump_on_o;
  logic use_external_vbus_indicator_i, indicator_polarity_invert_i;
  logic indicator_passthrough_i, external_supply_enable_i;
  logic internal_pump_enable_i, low_power_i, rx_valid_i, rx_last_i;
  logic rx_ready_o, rd_req_i, rd_ack_o, tx_valid_o, tx_last_o;
  logic go, abort, link_oe, busy, p;
  logic [1:0] line_state_i, vbus_state_i;
  logic [7:0] data_i, data_o, rx_data_i, rd_data_i, tx_data_o, link_data;
  logic [7:0] stat_q, rdb_q;
  logic [7:0] txq[$], rxq[$];
  int fail_count, n_checks, lastc;
  // Bus level from both drivers, weak pull-down when nobody drives
  assign data_i = data_oe_o ? data_o : (link_oe ? link_data : 8'h00);
  ulp_pin_control #(.POWERUP_CYC(2)) dut (.clk_i, .resetn_i, .select_n_i,
    .stp_i, .data_i, .data_o, .data_oe_o, .dir_o, .dir_oe_o, .nxt_o,
    .nxt_oe_o, .ifclk_o, .fault_i, .cable_role_pin_i, .cable_role_o,
    .ext_power_switch_n_o, .ext_power_switch_n_oe_o, .pump_on_o,
    .use_external_vbus_indicator_i, .indicator_polarity_invert_i,
    .indicator_passthrough_i, .external_supply_enable_i,
    .internal_pump_enable_i, .low_power_i, .line_state_i, .vbus_state_i,
    .rx_valid_i, .rx_data_i, .rx_last_i, .rx_ready_o, .rd_req_i, .rd_data_i,
    .rd_ack_o, .tx_data_o, .tx_valid_o, .tx_last_o);
  ulp_link_model link (.clk_i, .resetn_i, .dir_i(dir_o), .nxt_i(nxt_o),
    .go_i(go), .abort_i(abort), .pkt_i(24'h411234), .data_o(link_data),
    .data_oe_o(link_oe), .stp_o(stp_i), .busy_o(busy));
  // ==========================================================
  // Monitors: registered outputs are taken at the edge that ends them
  always @(posedge clk_i) begin
    if (tx_valid_o) txq.push_back(tx_data_o);
    if (tx_last_o) lastc++;
    if (dir_o && data_oe_o && nxt_o) rxq.push_back(data_o);
    if (dir_o && data_oe_o && !nxt_o && !rd_ack_o) stat_q = data_o;
    if (rd_ack_o) rdb_q = data_o;
  end
  // ==========================================================
  // Helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask : cyc
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_of_test
  // ==========================================================
  // Scenarios
  task automatic t_powerup();
    chk(dir_o, 1'b1);
    p = ifclk_o;
    cyc(1);
    chk(ifclk_o, !p);
    while (dir_o) cyc(1);
    chk({nxt_o, data_oe_o}, 2'h0);
    $display("powerup done");
  endtask : t_powerup
  task automatic t_power();
    external_supply_enable_i = 1'b1;
    internal_pump_enable_i = 1'b1;
    cyc(2);
    chk({ext_power_switch_n_oe_o, ext_power_switch_n_o}, 2'h2);
    chk({pump_on_o, cable_role_o}, 2'h3);
    $display("power done");
  endtask : t_power
  task automatic t_status();
    while (stat_q !== 8'h4d) cyc(1);
    chk(stat_q, 8'h4d);
    use_external_vbus_indicator_i = 1'b1;
    indicator_passthrough_i = 1'b1;
    fault_i = 1'b1;
    while (stat_q !== 8'h41) cyc(1);
    chk(stat_q, 8'h41);
    external_supply_enable_i = 1'b0;
    indicator_polarity_invert_i = 1'b1;
    while (stat_q !== 8'h4d) cyc(1);
    chk({stat_q, ext_power_switch_n_oe_o}, 9'h09a);
    $display("status done");
  endtask : t_status
  task automatic t_tx();
    cyc(6);
    go = 1'b1;
    cyc(1);
    go = 1'b0;
    while (busy) cyc(1);
    cyc(2);
    chk(8'(txq.size()), 8'h03);
    chk(txq[0], 8'h41);
    chk(txq[1], 8'h12);
    chk(txq[2], 8'h34);
    chk(8'(lastc), 8'h01);
    $display("tx done");
  endtask : t_tx
  task automatic t_read();
    rd_data_i = 8'ha5;
    rd_req_i = 1'b1;
    cyc(1);
    rd_req_i = 1'b0;
    cyc(8);
    chk({rdb_q, dir_o}, 9'h14a);
    $display("read done");
  endtask : t_read
  task automatic t_rx();
    rx_valid_i = 1'b1;
    rx_data_i = 8'h11;
    // Ready is judged before the edge that takes the byte
    while (!rx_ready_o) cyc(1);
    cyc(1);
    rx_data_i = 8'h22;
    rx_last_i = 1'b1;
    while (!rx_ready_o) cyc(1);
    cyc(1);
    rx_valid_i = 1'b0;
    rx_last_i = 1'b0;
    chk(rx_ready_o, 1'b0);
    while (dir_o) cyc(1);
    chk({rxq[0], rxq[1], 8'(rxq.size())}, 24'h112202);
    $display("rx done");
  endtask : t_rx
  task automatic t_abort();
    rx_valid_i = 1'b1;
    rx_data_i = 8'h33;
    while (!(dir_o && data_oe_o)) cyc(1);
    abort = 1'b1;
    rx_valid_i = 1'b0;
    cyc(1);
    chk(dir_o, 1'b0);
    abort = 1'b0;
    cyc(4);
    $display("abort done");
  endtask : t_abort
  task automatic t_select();
    select_n_i = 1'b1;
    cyc(2);
    chk({dir_oe_o, nxt_oe_o}, 2'h0);
    select_n_i = 1'b0;
    cyc(2);
    chk({dir_oe_o, nxt_oe_o}, 2'h3);
    $display("select done");
  endtask : t_select
  task automatic t_lowpower();
    low_power_i = 1'b1;
    while (!dir_o) cyc(1);
    cyc(2);
    p = ifclk_o;
    cyc(1);
    chk({dir_o, p, ifclk_o}, 3'h4);
    low_power_i = 1'b0;
    while (dir_o) cyc(1);
    chk(data_oe_o, 1'b0);
    // Host end of the cable: role bit clears in the next status byte
    cable_role_pin_i = 1'b0;
    while (stat_q !== 8'h0d) cyc(1);
    chk({stat_q, cable_role_o}, 9'h01a);
    $display("lowpower done");
  endtask : t_lowpower
  // ==========================================================
  // Clock, 50 ns period
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  // Watchdog: all scenarios need well under 4000 cycles
  initial begin
    #(50 * 4000);
    fail_count++;
    end_of_test();
  end
  // Main sequence
  initial begin
    {resetn_i, select_n_i, fault_i, go, abort, low_power_i} = 6'h0;
    {rx_valid_i, rx_last_i, rd_req_i, rx_data_i, rd_data_i} = 19'h0;
    {use_external_vbus_indicator_i, indicator_polarity_invert_i} = 2'h0;
    {indicator_passthrough_i, external_supply_enable_i} = 2'h0;
    internal_pump_enable_i = 1'b0;
    cable_role_pin_i = 1'b1;
    line_state_i = 2'h1;
    vbus_state_i = 2'h3;
    cyc(6);
    resetn_i = 1'b1;
    t_powerup();
    t_power();
    t_status();
    t_tx();
    t_read();
    t_rx();
    t_abort();
    t_select();
    t_lowpower();
    end_of_test();
  end
endmodule : ulp_pin_control_tb_top
`default_nettype wire
